// ===== hdl/bscr_regs.sv
// bscr_regs: board status and control register bank on the host i/o bus, with swap control.
// assumes host i/o strobes are one-cycle pulses synchronous to REF_CLK.
`default_nettype none
//
// How it works
// [R1] claim host i/o 0x0210-0x024F and 0x0310-0x031F for board registers
// [R2] first byte at 0x0210, third at 0x0211, second 0x0212, fourth 0x021D
// [R3] long timer count bytes 0x0218-0x021B, its control byte at 0x021C
// [R4] watchdog status and control byte at 0x0214
// [R5] pin control 0x031C, serial config 0x031D, slot identifier 0x031E
// [R6] scratch bytes 0x0221, 0x0222, 0x0228; version 0x0220; switches 0x0223-0x0225
// [R7] interrupt control 0x0229, further control bytes 0x022A and 0x022B
// [R8] pin interrupt control bytes at 0x031A and 0x031B
// [R9] error capture control 0x0320, captured address bytes 0x0321-0x0325
// [R10] microcontroller data 0x0CA9, control 0x0CAA, flags 0x0CAB
// [R11] read/clear bit: writing zero clears, writing one keeps
// [R12] read/set bit: writing zero keeps, writing one sets
// [R13] software writes reserved bits back unchanged and ignores their read value
// [R14] first byte bit 7 shows console switch
// [R15] first byte bit 6 shows setup defaults switch
// [R16] first byte bits 5..3 are swap enables, reset to zero
// [R17] first byte bits 2..0 show board revision code
// [R18] swapping only aligned; 64-bit handled as two 32-bit words
// [R19] decode cycle, set swap muxes, stall writes until muxes set
// [R20] fast swap bit skips the write stall
// [R21] second byte bit 7 is the read/clear button event flag
// [R22] button event sets flag; a same-cycle event beats the clear
// [R23] undecoded offsets and reserved bits read zero, writes ignored

module bscr_regs (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // host i/o cycle
    input wire bscr_pkg::bscr_io_req_t IO_REQ,
    output var logic [7:0] IO_RDATA,
    output var logic IO_RVALID,
    output var logic IO_CLAIM,
    // board straps and captured values
    input wire logic CONSOLE_SWITCH,
    input wire logic SETUP_DEFAULTS_SWITCH,
    input wire logic [2:0] BOARD_REVISION_CODE,
    input wire logic [7:0] HW_VERSION,
    input wire logic [23:0] SWITCH_BANKS,
    input wire logic [7:0] SLOT_ID,
    input wire logic [39:0] ERR_CAPTURE,
    input wire logic BUTTON_NMI_EVENT,
    // backplane cycle and swap control
    input wire bscr_pkg::bscr_bp_cycle_t BP_CYCLE,
    output var logic [2:0] SWAP_ENABLES,
    output var logic SWAP_MUX_EN,
    output var logic SWAP_WORD_HI,
    output var logic BP_WRITE_STALL
);
    import bscr_pkg::*;

    bscr_state_t st;
    bscr_state_t nxt;
    logic [NSTORE-1:0] store_hit;
    logic claimed;
    logic swap_ok;
    logic [7:0] rd_byte;
    logic [2:0] cap_idx;

    // per-entry address match of the plain bytes
    genvar gi;
    for (gi = 0; gi < NSTORE; gi++)
    begin : g_hit
        assign store_hit[gi] = (IO_REQ.addr == STORE_OFS[gi]); // [R3] [R4] [R6] [R7] [R8]
    end

    // read/set merge, plain bits stored as written
    function automatic logic [7:0] rs_merge(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] rs_mask);
        rs_merge = (wd & ~rs_mask) | ((old | wd) & rs_mask); // [R12]
    endfunction

    always_comb
    begin
        claimed = ((IO_REQ.addr >= CLAIM_A_LO) && (IO_REQ.addr <= CLAIM_A_HI))
            || ((IO_REQ.addr >= CLAIM_B_LO) && (IO_REQ.addr <= CLAIM_B_HI))
            || ((IO_REQ.addr >= CLAIM_C_LO) && (IO_REQ.addr <= CLAIM_C_HI))
            || ((IO_REQ.addr >= CLAIM_D_LO) && (IO_REQ.addr <= CLAIM_D_HI)); // [R1] [R9] [R10]
        swap_ok = BP_CYCLE.slave ? st.swap_en[SWAP_SLAVE_IDX] : st.swap_en[SWAP_MASTER_IDX];
        // kept at three bits so the byte index can never go negative
        cap_idx = IO_REQ.addr[2:0] - 3'd1;
        rd_byte = 8'h00; // [R23]
        for (int i = 0; i < NSTORE; i++)
        begin
            if (store_hit[i])
            begin
                rd_byte = st.store[i]; // [R5] [R10]
            end
        end
        case (IO_REQ.addr)
            OFS_BOARD_SC0:
            begin
                rd_byte = {CONSOLE_SWITCH, SETUP_DEFAULTS_SWITCH, st.swap_en,
                    BOARD_REVISION_CODE}; // [R2] [R14] [R15] [R17]
            end
            OFS_BOARD_SC1:
            begin
                rd_byte = {st.nmi_flag, 7'h00}; // [R2] [R21] [R23]
            end
            OFS_HW_VERSION:
            begin
                rd_byte = HW_VERSION; // [R6]
            end
            OFS_SWITCH_1:
            begin
                rd_byte = SWITCH_BANKS[7:0]; // [R6]
            end
            OFS_SWITCH_2:
            begin
                rd_byte = SWITCH_BANKS[15:8]; // [R6]
            end
            OFS_SWITCH_3:
            begin
                rd_byte = SWITCH_BANKS[23:16]; // [R6]
            end
            OFS_SLOT_ID:
            begin
                rd_byte = SLOT_ID; // [R5]
            end
            OFS_CAPTURE_1, 16'h0322, 16'h0323, 16'h0324, OFS_CAPTURE_5:
            begin
                rd_byte = ERR_CAPTURE[8*cap_idx +: 8]; // [R9]
            end
            OFS_MCU_FLAGS:
            begin
                rd_byte = 8'h00; // [R10]
            end
            default:
            begin
                rd_byte = rd_byte;
            end
        endcase

        nxt = st;
        nxt.rvalid = IO_REQ.rd;
        nxt.rdata = IO_REQ.rd ? rd_byte : 8'h00;
        nxt.claim = (IO_REQ.rd || IO_REQ.wr) && claimed; // [R1]

        if (IO_REQ.wr)
        begin
            for (int i = 0; i < NSTORE; i++)
            begin
                if (store_hit[i])
                begin
                    nxt.store[i] = rs_merge(st.store[i], IO_REQ.wdata,
                        (STORE_OFS[i] == OFS_CAPTURE_CTRL) ? CAPTURE_RS_MASK : 8'h00); // [R12]
                end
            end
            if (IO_REQ.addr == OFS_BOARD_SC0)
            begin
                nxt.swap_en = IO_REQ.wdata[SC0_SWAP_MSB:SC0_SWAP_LSB]; // [R16]
            end
        end

        // read/clear flag, a new event wins over the clear
        if (IO_REQ.wr && (IO_REQ.addr == OFS_BOARD_SC1) && !IO_REQ.wdata[SC1_NMI_BIT])
        begin
            nxt.nmi_flag = 1'b0; // [R11] [R21]
        end
        if (BUTTON_NMI_EVENT)
        begin
            nxt.nmi_flag = 1'b1; // [R22]
        end

        // swap sequencing for backplane cycles
        case (st.sw)
            SW_IDLE:
            begin
                if (BP_CYCLE.start && BP_CYCLE.aligned && swap_ok) // [R18]
                begin
                    nxt.sw_write = BP_CYCLE.write;
                    nxt.sw_wide = BP_CYCLE.wide;
                    nxt.word_hi = 1'b0;
                    if (st.swap_en[SWAP_FAST_IDX])
                    begin
                        nxt.sw = SW_ACTIVE; // [R20]
                        nxt.mux_en = 1'b1;
                    end
                    else
                    begin
                        nxt.sw = SW_DECODE; // [R19]
                        nxt.stall = BP_CYCLE.write;
                    end
                end
            end
            SW_DECODE:
            begin
                nxt.sw = SW_ACTIVE; // [R19]
                nxt.mux_en = 1'b1;
                nxt.stall = 1'b0;
            end
            SW_ACTIVE:
            begin
                if (BP_CYCLE.word_done)
                begin
                    if (st.sw_wide)
                    begin
                        nxt.sw = SW_SECOND; // [R18]
                        nxt.word_hi = 1'b1;
                    end
                    else
                    begin
                        nxt.sw = SW_IDLE;
                        nxt.mux_en = 1'b0;
                    end
                end
            end
            SW_SECOND:
            begin
                if (BP_CYCLE.word_done)
                begin
                    nxt.sw = SW_IDLE;
                    nxt.mux_en = 1'b0;
                    nxt.word_hi = 1'b0;
                end
            end
            default:
            begin
                nxt.sw = SW_IDLE;
                nxt.mux_en = 1'b0;
                nxt.word_hi = 1'b0;
                nxt.stall = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st <= '{store: {NSTORE{STORE_RST}}, swap_en: SWAP_EN_RST, sw: SW_IDLE,
                default: '0}; // [R16]
        end
        else
        begin
            st <= nxt;
        end
    end

    assign IO_RDATA = st.rdata;
    assign IO_RVALID = st.rvalid;
    assign IO_CLAIM = st.claim;
    assign SWAP_ENABLES = st.swap_en;
    assign SWAP_MUX_EN = st.mux_en;
    assign SWAP_WORD_HI = st.word_hi;
    assign BP_WRITE_STALL = st.stall;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_slow_write_start;
        st.sw == SW_IDLE && BP_CYCLE.start && BP_CYCLE.aligned && BP_CYCLE.write
            && swap_ok && !st.swap_en[SWAP_FAST_IDX];
    endsequence
    sequence s_stall_then_set;
        BP_WRITE_STALL && !SWAP_MUX_EN ##1 !BP_WRITE_STALL && SWAP_MUX_EN;
    endsequence

    AST_NMI_SET: assert property (BUTTON_NMI_EVENT |=> st.nmi_flag) // [R22]
        else $error("button event did not set the flag");
    AST_NMI_CLEAR: assert property (IO_REQ.wr && IO_REQ.addr == OFS_BOARD_SC1
        && !IO_REQ.wdata[SC1_NMI_BIT] && !BUTTON_NMI_EVENT |=> !st.nmi_flag) // [R11]
        else $error("zero write did not clear the flag");
    AST_NMI_KEEP: assert property (st.nmi_flag && !(IO_REQ.wr && IO_REQ.addr == OFS_BOARD_SC1
        && !IO_REQ.wdata[SC1_NMI_BIT]) |=> st.nmi_flag) // [R21]
        else $error("flag dropped without a zero write");
    AST_SC0_READ: assert property (IO_REQ.rd && IO_REQ.addr == OFS_BOARD_SC0 |=>
        IO_RVALID && IO_RDATA[SC0_CONSOLE_BIT] == $past(CONSOLE_SWITCH)
        && IO_RDATA[SC0_DEFAULTS_BIT] == $past(SETUP_DEFAULTS_SWITCH)
        && IO_RDATA[2:0] == $past(BOARD_REVISION_CODE)) // [R14]
        else $error("first byte read back wrong");
    AST_SWAP_WRITE: assert property (IO_REQ.wr && IO_REQ.addr == OFS_BOARD_SC0 |=>
        SWAP_ENABLES == $past(IO_REQ.wdata[SC0_SWAP_MSB:SC0_SWAP_LSB])) // [R16]
        else $error("swap enables not written");
    AST_UNMAPPED: assert property (IO_REQ.rd && !claimed |=> IO_RDATA == 8'h00 && !IO_CLAIM) // [R23]
        else $error("unclaimed read returned data");
    AST_RS_BIT: assert property (IO_REQ.wr && IO_REQ.addr == OFS_CAPTURE_CTRL
        && st.store[18][0] |=> st.store[18][0]) // [R12]
        else $error("read/set bit cleared by a write");
    AST_WRITE_STALL: assert property (s_slow_write_start |=> s_stall_then_set) // [R19]
        else $error("write stall not one cycle before muxes set");
    AST_FAST_NO_STALL: assert property (st.sw == SW_IDLE && BP_CYCLE.start && BP_CYCLE.aligned
        && swap_ok && st.swap_en[SWAP_FAST_IDX] |=> !BP_WRITE_STALL && SWAP_MUX_EN) // [R20]
        else $error("fast swap stalled");
    AST_WIDE_HALVES: assert property (st.sw == SW_ACTIVE && st.sw_wide && BP_CYCLE.word_done
        |=> SWAP_WORD_HI && SWAP_MUX_EN) // [R18]
        else $error("second word of wide cycle not swapped");
    AST_READ_IDLE: assert property (!IO_REQ.rd |=> !IO_RVALID && IO_RDATA == 8'h00) // [R23]
        else $error("read answer without a read");
    AST_CLAIM: assert property ((IO_REQ.rd || IO_REQ.wr) && claimed |=> IO_CLAIM) // [R1]
        else $error("claimed address not acknowledged");
    AST_STALL_ONE: assert property (BP_WRITE_STALL |=> !BP_WRITE_STALL) // [R19]
        else $error("write stall held longer than one cycle");
    AST_NOT_SWAPPED: assert property (st.sw == SW_IDLE && BP_CYCLE.start
        && !(BP_CYCLE.aligned && swap_ok) |=> !SWAP_MUX_EN && !BP_WRITE_STALL) // [R18]
        else $error("unswappable cycle started the swap logic");
    AST_SWITCH_BYTE: assert property (IO_REQ.rd && IO_REQ.addr == OFS_SWITCH_2 |=>
        IO_RDATA == $past(SWITCH_BANKS[15:8])) // [R6]
        else $error("middle switch byte read back wrong");
    AST_MCU_FLAGS_ZERO: assert property (IO_REQ.rd && IO_REQ.addr == OFS_MCU_FLAGS |=>
        IO_RDATA == 8'h00) // [R10]
        else $error("flags byte returned data");

endmodule

`default_nettype wire

// ===== hdl/bscr_pkg.sv
// bscr_pkg: constants, register offsets and carrier types of the board status and control bank.
// assumes a single 250 MHz clock and host i/o cycles already synchronous to it.
`default_nettype none

package bscr_pkg;

    // claimed host i/o windows
    localparam logic [15:0] CLAIM_A_LO = 16'h0210;
    localparam logic [15:0] CLAIM_A_HI = 16'h024F;
    localparam logic [15:0] CLAIM_B_LO = 16'h0310;
    localparam logic [15:0] CLAIM_B_HI = 16'h031F;
    localparam logic [15:0] CLAIM_C_LO = 16'h0320;
    localparam logic [15:0] CLAIM_C_HI = 16'h0325;
    localparam logic [15:0] CLAIM_D_LO = 16'h0CA9;
    localparam logic [15:0] CLAIM_D_HI = 16'h0CAB;

    // register offsets
    localparam logic [15:0] OFS_BOARD_SC0 = 16'h0210;
    localparam logic [15:0] OFS_BOARD_SC2 = 16'h0211;
    localparam logic [15:0] OFS_BOARD_SC1 = 16'h0212;
    localparam logic [15:0] OFS_WATCHDOG_SC = 16'h0214;
    localparam logic [15:0] OFS_LTIMER_B0 = 16'h0218;
    localparam logic [15:0] OFS_LTIMER_B1 = 16'h0219;
    localparam logic [15:0] OFS_LTIMER_B2 = 16'h021A;
    localparam logic [15:0] OFS_LTIMER_B3 = 16'h021B;
    localparam logic [15:0] OFS_LTIMER_SC = 16'h021C;
    localparam logic [15:0] OFS_BOARD_SC3 = 16'h021D;
    localparam logic [15:0] OFS_HW_VERSION = 16'h0220;
    localparam logic [15:0] OFS_SCRATCH_1 = 16'h0221;
    localparam logic [15:0] OFS_SCRATCH_2 = 16'h0222;
    localparam logic [15:0] OFS_SWITCH_1 = 16'h0223;
    localparam logic [15:0] OFS_SWITCH_2 = 16'h0224;
    localparam logic [15:0] OFS_SWITCH_3 = 16'h0225;
    localparam logic [15:0] OFS_SCRATCH_3 = 16'h0228;
    localparam logic [15:0] OFS_INT_CTRL = 16'h0229;
    localparam logic [15:0] OFS_BOARD_SC4 = 16'h022A;
    localparam logic [15:0] OFS_BOARD_SC5 = 16'h022B;
    localparam logic [15:0] OFS_PIN_IRQ_0 = 16'h031A;
    localparam logic [15:0] OFS_PIN_IRQ_1 = 16'h031B;
    localparam logic [15:0] OFS_PIN_SC = 16'h031C;
    localparam logic [15:0] OFS_SERIAL_CFG = 16'h031D;
    localparam logic [15:0] OFS_SLOT_ID = 16'h031E;
    localparam logic [15:0] OFS_CAPTURE_CTRL = 16'h0320;
    localparam logic [15:0] OFS_CAPTURE_1 = 16'h0321;
    localparam logic [15:0] OFS_CAPTURE_5 = 16'h0325;
    localparam logic [15:0] OFS_MCU_DATA = 16'h0CA9;
    localparam logic [15:0] OFS_MCU_CS = 16'h0CAA;
    localparam logic [15:0] OFS_MCU_FLAGS = 16'h0CAB;

    // plain software-held bytes
    localparam int NSTORE = 21;
    localparam logic [15:0] STORE_OFS [NSTORE] = '{
        OFS_BOARD_SC2, OFS_WATCHDOG_SC, OFS_LTIMER_B0, OFS_LTIMER_B1, OFS_LTIMER_B2,
        OFS_LTIMER_B3, OFS_LTIMER_SC, OFS_BOARD_SC3, OFS_SCRATCH_1, OFS_SCRATCH_2,
        OFS_SCRATCH_3, OFS_INT_CTRL, OFS_BOARD_SC4, OFS_BOARD_SC5, OFS_PIN_IRQ_0,
        OFS_PIN_IRQ_1, OFS_PIN_SC, OFS_SERIAL_CFG, OFS_CAPTURE_CTRL, OFS_MCU_DATA,
        OFS_MCU_CS
    };
    localparam logic [7:0] STORE_RST = 8'h00;
    // read/set bits of the capture control byte
    localparam logic [7:0] CAPTURE_RS_MASK = 8'h01;

    // field positions of the first status/control byte
    localparam int SC0_CONSOLE_BIT = 7;
    localparam int SC0_DEFAULTS_BIT = 6;
    localparam int SC0_SWAP_LSB = 3;
    localparam int SC0_SWAP_MSB = 5;
    localparam int SWAP_FAST_IDX = 2;
    localparam int SWAP_SLAVE_IDX = 1;
    localparam int SWAP_MASTER_IDX = 0;
    localparam logic [2:0] SWAP_EN_RST = 3'h0;
    // field position of the button event flag
    localparam int SC1_NMI_BIT = 7;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } bscr_io_req_t;

    typedef struct packed {
        logic start;
        logic write;
        logic slave;
        logic aligned;
        logic wide;
        logic word_done;
    } bscr_bp_cycle_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_DECODE = 2'b01,
        SW_ACTIVE = 2'b11,
        SW_SECOND = 2'b10
    } bscr_swap_state_t;

    typedef struct packed {
        logic [NSTORE-1:0][7:0] store;
        logic [2:0] swap_en;
        logic nmi_flag;
        logic [7:0] rdata;
        logic rvalid;
        logic claim;
        bscr_swap_state_t sw;
        logic sw_write;
        logic sw_wide;
        logic mux_en;
        logic word_hi;
        logic stall;
    } bscr_state_t;

endpackage

`default_nettype wire

// ===== sim/bscr_host.sv
// bscr_host: host processor model issuing byte i/o reads and writes to the bank.
// assumes the bank registers its answer on the edge that takes a strobe, so the answer is there in the cycle after that edge.
`default_nettype none

module bscr_host
    import bscr_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // host i/o cycle
    output var bscr_pkg::bscr_io_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic claim
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // one write cycle; released lines carry inverted values so nothing stale matches
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge ref_clk);
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    // one read cycle; returns {valid, claim, data} seen in the answer cycle
    task automatic rd(input logic [15:0] a, output logic [9:0] r);
        @(posedge ref_clk);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'hA5};
        @(posedge ref_clk);
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'h5A};
        @(negedge ref_clk);
        r = {rvalid, claim, rdata};
    endtask

    // update only the masked field and hand other bits back as read
    task automatic rmw(input logic [15:0] a, input logic [7:0] m, input logic [7:0] v);
        logic [9:0] r;
        rd(a, r);
        wr(a, (r[7:0] & ~m) | (v & m));
    endtask
endmodule

`default_nettype wire

// ===== sim/tb_bscr_regs.sv
// tb_bscr_regs: self-checking bench for the board status and control bank.
// assumes bscr_pkg, bscr_regs and the bscr_host model are compiled before it.
`default_nettype none

module tb_bscr_regs
    import bscr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] RO_A [10] = '{OFS_HW_VERSION, OFS_SWITCH_1, OFS_SWITCH_2,
        OFS_SWITCH_3, OFS_SLOT_ID, OFS_CAPTURE_1, 16'h0322, 16'h0323, 16'h0324, OFS_CAPTURE_5};
    localparam logic [15:0] UN_A [6] = '{16'h0213, 16'h024F, 16'h0CAB, 16'h031F,
        16'h0250, 16'h0300};
    localparam logic [5:0] UN_C = 6'h0F;

    logic ref_clk;
    logic rstn;
    bscr_io_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic claim;
    logic console;
    logic defaults;
    logic [2:0] rev;
    logic [7:0] hw;
    logic [23:0] sw;
    logic [7:0] slot;
    logic [39:0] cap;
    logic btn;
    bscr_bp_cycle_t bp;
    logic [2:0] swap_en;
    logic mux_en;
    logic word_hi;
    logic stall;
    logic [79:0] ro_v;
    int err_total = 0;
    int tests_run = 0;

    assign ro_v = {cap, slot, sw, hw};

    bscr_regs DUT (
        .REF_CLK(ref_clk),
        .RSTN(rstn),
        .IO_REQ(req),
        .IO_RDATA(rdata),
        .IO_RVALID(rvalid),
        .IO_CLAIM(claim),
        .CONSOLE_SWITCH(console),
        .SETUP_DEFAULTS_SWITCH(defaults),
        .BOARD_REVISION_CODE(rev),
        .HW_VERSION(hw),
        .SWITCH_BANKS(sw),
        .SLOT_ID(slot),
        .ERR_CAPTURE(cap),
        .BUTTON_NMI_EVENT(btn),
        .BP_CYCLE(bp),
        .SWAP_ENABLES(swap_en),
        .SWAP_MUX_EN(mux_en),
        .SWAP_WORD_HI(word_hi),
        .BP_WRITE_STALL(stall)
    );

    bscr_host host (
        .ref_clk(ref_clk),
        .req(req),
        .rdata(rdata),
        .rvalid(rvalid),
        .claim(claim)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] d, input logic c);
        logic [9:0] r;
        host.rd(a, r);
        chk(r, {1'b1, c, d});
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 17 + 129);
    endfunction

    // one backplane cycle q = {write, slave, aligned, wide}; lat 0 means not swapped
    task automatic cyc(input logic [3:0] q, input int lat, input logic stl);
        @(posedge ref_clk);
        bp <= {1'b1, q, 1'b0};
        @(posedge ref_clk);
        bp <= '0;
        @(negedge ref_clk);
        chk(stall, stl);
        if (lat == 2)
            @(negedge ref_clk);
        chk(mux_en, lat != 0);
        if (lat != 0)
            for (int n = q[0]; n >= 0; n--)
            begin
                @(posedge ref_clk);
                bp.word_done <= 1'b1;
                @(posedge ref_clk);
                bp.word_done <= 1'b0;
                @(negedge ref_clk);
                chk({word_hi, mux_en}, {n != 0, n != 0});
            end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        results();
    end

    initial
    begin
        rstn = 1'b0;
        bp = '0;
        btn = 1'b0;
        console = 1'b1;
        defaults = 1'b0;
        rev = 3'h2;
        hw = 8'h3C;
        sw = 24'h5A_C381;
        slot = 8'h96;
        cap = 40'h12_3456_789A;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        chk(swap_en, SWAP_EN_RST);
        rdc(OFS_BOARD_SC0, 8'h82, 1'b1);
        @(posedge ref_clk);
        console <= 1'b0;
        defaults <= 1'b1;
        rev <= 3'h1;
        rdc(OFS_BOARD_SC0, 8'h41, 1'b1);
        $display("test first byte done");
        for (int i = 0; i < NSTORE; i++)
            host.wr(STORE_OFS[i], pat(i));
        for (int i = 0; i < NSTORE; i++)
            rdc(STORE_OFS[i], pat(i), 1'b1);
        host.wr(OFS_CAPTURE_CTRL, 8'h00);
        rdc(OFS_CAPTURE_CTRL, 8'h01, 1'b1);
        $display("test storage done");
        for (int i = 0; i < 10; i++)
        begin
            host.wr(RO_A[i], ~ro_v[8*i +: 8]);
            rdc(RO_A[i], ro_v[8*i +: 8], 1'b1);
        end
        for (int i = 0; i < 6; i++)
        begin
            host.wr(UN_A[i], 8'hFF);
            rdc(UN_A[i], 8'h00, UN_C[i]);
        end
        $display("test read-only and undecoded done");
        rdc(OFS_BOARD_SC1, 8'h00, 1'b1);
        @(posedge ref_clk);
        btn <= 1'b1;
        @(posedge ref_clk);
        btn <= 1'b0;
        rdc(OFS_BOARD_SC1, 8'h80, 1'b1);
        host.wr(OFS_BOARD_SC1, 8'h80);
        rdc(OFS_BOARD_SC1, 8'h80, 1'b1);
        fork
            host.wr(OFS_BOARD_SC1, 8'h00);
            begin
                @(posedge ref_clk);
                btn <= 1'b1;
                @(posedge ref_clk);
                btn <= 1'b0;
            end
        join
        rdc(OFS_BOARD_SC1, 8'h80, 1'b1);
        host.wr(OFS_BOARD_SC1, 8'h00);
        rdc(OFS_BOARD_SC1, 8'h00, 1'b1);
        $display("test button flag done");
        host.rmw(OFS_BOARD_SC0, 8'h38, 8'h10);
        @(negedge ref_clk);
        chk(swap_en, 3'h2);
        cyc(4'b1110, 2, 1'b1);
        cyc(4'b0111, 2, 1'b0);
        cyc(4'b1100, 0, 1'b0);
        cyc(4'b1010, 0, 1'b0);
        host.rmw(OFS_BOARD_SC0, 8'h38, 8'h30);
        @(negedge ref_clk);
        chk(swap_en, 3'h6);
        cyc(4'b1111, 1, 1'b0);
        $display("test swap done");
        host.wr(OFS_SCRATCH_1, 8'h5A);
        @(posedge ref_clk);
        btn <= 1'b1;
        @(posedge ref_clk);
        btn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(negedge ref_clk);
        chk({swap_en, word_hi, mux_en, stall}, {SWAP_EN_RST, 3'h0});
        @(posedge ref_clk);
        rstn <= 1'b1;
        rdc(OFS_SCRATCH_1, STORE_RST, 1'b1);
        rdc(OFS_BOARD_SC1, 8'h00, 1'b1);
        rdc(OFS_BOARD_SC0, 8'h41, 1'b1);
        $display("test mid-run reset done");
        results();
    end
endmodule

`default_nettype wire
